/* File: core/ts_framer_regs.svh */
// Constants for the downstream transport packet framer and deframer
// Overview of operation
// - Stream is back-to-back 188-byte packets: 4 header bytes, 184 payload.
// - First header byte of every packet is the sync value 0x47.
// - Sender clears the error indicator; receiver drops packets flagged bad.
// - Start indicator set means payload byte one is a pointer byte.
// - Priority bit zero and scrambling control '00' on data packets.
// - Data packets carry identifier 0x1FFE; receiver selects on it.
// - Adaptation control always '01'; payload follows header directly.
// - Four-bit continuity counter advances per data packet and wraps.
// - Gaps between frames are 0xFF filler; receiver skips them.
// - A frame control byte never equals 0xFF, so 0xFF is filler.
// - Pointer counts payload bytes skipped before the frame search starts.
// - Pointer present where a frame can start; addresses frame or filler.
// - Frames start anywhere, span packets, several may share one packet.
// - Frame right after pointer gives pointer zero; search starts next byte.
// - Packet without start indicator: all 184 bytes continue current frame.
// - Pointer after a spanning frame counts exactly that frame's tail bytes.
// - A newly ready frame replaces pending filler at once, mid-packet.
// - Send null packets instead of data packets holding only filler.
// - Mixing with other services keeps the MAC timing relationships.
// - Other-service interleave is optional; payload type from identifier.
// - Accurate timestamp inserted into sync messages as they are sent.
// - Alignment acquired after five consecutive good checksums.
// - Alignment lost after nine consecutive bad checksums; search restarts.
`ifndef TS_FRAMER_REGS_SVH
`define TS_FRAMER_REGS_SVH

`define TS_PKT_LEN 188
`define TS_HDR_LEN 4
`define TS_PAYLOAD_LEN 184
`define TS_PTR_MAX 8'hB7
`define TS_SYNC 8'h47
`define TS_PID_DATA 13'h1FFE
`define TS_PID_NULL 13'h1FFF
`define TS_STUFF 8'hFF
`define TS_SCR_CLEAR 2'h0
`define TS_AFC_PAYLOAD 2'h1
`define TS_TEI_BIT 7
`define TS_PUSI_BIT 6
`define TS_ACQ_RUN 5
`define TS_LOSS_RUN 9
`define TS_STAMP_BYTES 4

`endif

/* File: core/ts_framer_pkg.sv */
// Types shared by the transport framer modules
package ts_framer_pkg;

  // Kind of packet being sent
  typedef enum logic [1:0] {
    KIND_DATA = 2'b00,
    KIND_OTHER = 2'b01,
    KIND_NULL = 2'b10
  } tx_kind_t;

  // Receive frame delineation state
  typedef enum logic [1:0] {
    RX_LOST = 2'b00,
    RX_HUNT = 2'b01,
    RX_FRAME = 2'b10
  } rx_mode_t;

endpackage

/* File: core/pkt_pos_counter.sv */
// Byte position counter within a transport packet
module pkt_pos_counter #(
  parameter int LEN = 188
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control
  input wire logic step,
  input wire logic restart,
  // Position
  output logic [7:0] count
);

  wire last = (count == 8'(LEN - 1));

  // Restart marks the stepped byte as position zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= 8'h00;
    end else if (step) begin
      if (restart) begin
        count <= (LEN > 1) ? 8'h01 : 8'h00;
      end else if (last) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule

/* File: core/run_counter.sv */
// Counts consecutive hits, cleared by a miss, saturating at RUN
module run_counter #(
  parameter int RUN = 5
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Events
  input wire logic hit,
  input wire logic miss,
  // Run length reached
  output logic reached
);

  logic [3:0] run;
  wire at_run = (run == 4'(RUN));

  // A miss wins over a hit so a run never survives a bad result
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      run <= 4'h0;
    end else if (miss) begin
      run <= 4'h0;
    end else if (hit && !at_run) begin
      run <= run + 4'h1;
    end
  end

  assign reached = at_run;

endmodule

/* File: core/downstream_ts_mac_framer.sv */
// Downstream transport convergence: MAC frame packing and recovery
`include "ts_framer_regs.svh"

module downstream_ts_mac_framer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Transmit control
  input wire logic tx_enable,
  input wire logic [31:0] tstamp,
  // Transmit MAC byte source
  input wire logic mac_valid,
  input wire logic [7:0] mac_data,
  input wire logic mac_sof,
  input wire logic [15:0] mac_len,
  input wire logic mac_stamp,
  output logic mac_take,
  // Other-service packet source
  input wire logic other_req,
  input wire logic [7:0] other_data,
  output logic other_take,
  // Transmit coder side
  input wire logic phy_next,
  output logic [7:0] tx_data,
  output logic tx_valid,
  output logic tx_sop,
  // Receive decoder side
  input wire logic rx_valid,
  input wire logic rx_sop,
  input wire logic [7:0] rx_data,
  input wire logic rx_cks_ok,
  input wire logic rx_cks_bad,
  // Receive MAC side
  input wire logic mac_rx_end,
  output logic [7:0] rx_out_data,
  output logic rx_out_valid,
  output logic rx_out_sof,
  // Receive status
  output logic rx_in_frame,
  output logic rx_ptr_err
);

  // Transmit path: header build, pointer, filler and frame bytes
  logic [7:0] tx_pos;
  ts_framer_pkg::tx_kind_t kind;
  logic tx_pusi;
  logic [15:0] frame_left;
  logic [3:0] cc;
  logic [1:0] stamp_idx;
  logic [31:0] stamp_sh;

  pkt_pos_counter #(
    .LEN(`TS_PKT_LEN)
  ) u_tx_pos (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step(phy_next),
    .restart(1'b0),
    .count(tx_pos)
  );

  // Packet kind chosen at the sync byte; data wins so MAC timing holds
  wire at_start = (tx_pos == 8'h00);
  wire mac_new = tx_enable && mac_valid && mac_sof;
  wire want_data = (frame_left != 16'h0000) || mac_new;
  ts_framer_pkg::tx_kind_t next_kind;
  assign next_kind = want_data ? ts_framer_pkg::KIND_DATA :
    (other_req ? ts_framer_pkg::KIND_OTHER :
     ts_framer_pkg::KIND_NULL);
  ts_framer_pkg::tx_kind_t cur_kind;
  assign cur_kind = at_start ? next_kind : kind;

  // Pointer only where a frame could start; tail length is the pointer
  wire next_pusi = (frame_left < 16'(`TS_PAYLOAD_LEN));
  wire [7:0] tail_ptr = frame_left[7:0];
  wire is_ptr_byte = (tx_pos == 8'(`TS_HDR_LEN)) && tx_pusi;
  wire in_payload = (tx_pos >= 8'(`TS_HDR_LEN)) && !is_ptr_byte;
  wire is_data = (cur_kind == ts_framer_pkg::KIND_DATA);

  // Frame continues, or a waiting frame replaces filler at once
  wire cont_byte = in_payload && is_data && (frame_left != 16'h0000);
  wire start_byte = in_payload && is_data && (frame_left == 16'h0000)
    && mac_new;
  wire mac_byte = cont_byte || start_byte;
  wire [15:0] new_left = (mac_len == 16'h0000) ? 16'h0000
    : mac_len - 16'h0001;

  // Timestamp substituted from the live counter at send time
  wire stamp_now = mac_byte && mac_stamp;
  wire [7:0] stamp_byte = (stamp_idx == 2'h0) ? tstamp[31:24]
    : stamp_sh[31:24];
  wire [7:0] mac_out = stamp_now ? stamp_byte : mac_data;

  // Header field bytes for data and null packets
  wire [12:0] pid = (cur_kind == ts_framer_pkg::KIND_NULL) ?
    `TS_PID_NULL : `TS_PID_DATA;
  wire hdr_pusi = at_start ? (is_data && next_pusi) : tx_pusi;
  wire [7:0] hdr1 = {1'b0, hdr_pusi, 1'b0, pid[12:8]};
  wire [7:0] hdr2 = pid[7:0];
  wire [3:0] hdr_cc = is_data ? cc : 4'h0;
  wire [7:0] hdr3 = {`TS_SCR_CLEAR, `TS_AFC_PAYLOAD, hdr_cc};

  // Byte selection for the next coder strobe
  logic [7:0] next_byte;
  always_comb begin
    next_byte = `TS_STUFF;
    if (cur_kind == ts_framer_pkg::KIND_OTHER) begin
      next_byte = other_data;
    end else begin
      case (tx_pos)
        8'h00: next_byte = `TS_SYNC;
        8'h01: next_byte = hdr1;
        8'h02: next_byte = hdr2;
        8'h03: next_byte = hdr3;
        default: begin
          if (is_ptr_byte) begin
            next_byte = tail_ptr;
          end else if (mac_byte) begin
            next_byte = mac_out;
          end
        end
      endcase
    end
  end

  // Per-packet state latched at the sync byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      kind <= ts_framer_pkg::KIND_NULL;
      tx_pusi <= 1'b0;
    end else if (phy_next && at_start) begin
      kind <= next_kind;
      tx_pusi <= is_data && next_pusi;
    end
  end

  // Remaining bytes of the frame in flight
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_left <= 16'h0000;
    end else if (phy_next && start_byte) begin
      frame_left <= new_left;
    end else if (phy_next && cont_byte) begin
      frame_left <= frame_left - 16'h0001;
    end
  end

  // Continuity counter counts data packets only, wrapping mod 16
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cc <= 4'h0;
    end else if (phy_next && is_data && tx_pos == 8'h03) begin
      cc <= cc + 4'h1;
    end
  end

  // Timestamp byte sequencer, four bytes most significant first
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stamp_idx <= 2'h0;
      stamp_sh <= 32'h0000_0000;
    end else if (phy_next && stamp_now) begin
      stamp_idx <= stamp_idx + 2'h1;
      if (stamp_idx == 2'h0) begin
        stamp_sh <= {tstamp[23:0], 8'h00};
      end else begin
        stamp_sh <= {stamp_sh[23:0], 8'h00};
      end
    end
  end

  // Registered coder outputs and source acknowledges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      tx_sop <= 1'b0;
      mac_take <= 1'b0;
      other_take <= 1'b0;
    end else begin
      tx_valid <= phy_next;
      tx_sop <= phy_next && at_start;
      mac_take <= phy_next && mac_byte;
      other_take <= phy_next
        && (cur_kind == ts_framer_pkg::KIND_OTHER);
      if (phy_next) begin
        tx_data <= next_byte;
      end
    end
  end

  // Receive path: packet acceptance and frame delineation
  logic [7:0] rx_cnt;
  logic good_run;
  logic bad_run;
  logic in_frame;
  logic rx_keep;
  logic rx_pusi;
  logic [4:0] rx_pid_hi;
  logic [7:0] rx_skip;
  ts_framer_pkg::rx_mode_t rx_mode;

  pkt_pos_counter #(
    .LEN(`TS_PKT_LEN)
  ) u_rx_pos (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step(rx_valid),
    .restart(rx_sop),
    .count(rx_cnt)
  );

  // Checksum run tracking for packet alignment
  run_counter #(
    .RUN(`TS_ACQ_RUN)
  ) u_good_run (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .hit(rx_cks_ok),
    .miss(rx_cks_bad),
    .reached(good_run)
  );

  run_counter #(
    .RUN(`TS_LOSS_RUN)
  ) u_bad_run (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .hit(rx_cks_bad),
    .miss(rx_cks_ok),
    .reached(bad_run)
  );

  // Alignment flag: acquired and lost on checksum runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      in_frame <= 1'b0;
    end else if (!in_frame && good_run) begin
      in_frame <= 1'b1;
    end else if (in_frame && bad_run) begin
      in_frame <= 1'b0;
    end
  end

  // Receive byte classification
  wire [7:0] rx_pos = rx_sop ? 8'h00 : rx_cnt;
  wire rx_hdr1 = rx_valid && rx_pos == 8'h01;
  wire rx_hdr2 = rx_valid && rx_pos == 8'h02;
  wire rx_hdr3 = rx_valid && rx_pos == 8'h03;
  wire rx_ptr = rx_valid && rx_keep && rx_pusi
    && rx_pos == 8'(`TS_HDR_LEN);
  wire rx_pay = rx_valid && rx_keep && !rx_ptr
    && rx_pos >= 8'(`TS_HDR_LEN);
  wire pid_match = ({rx_pid_hi, rx_data} == `TS_PID_DATA);
  wire ptr_bad = (rx_data > `TS_PTR_MAX);
  wire is_stuff = (rx_data == `TS_STUFF);

  // MAC signalling end of frame returns to the filler search
  ts_framer_pkg::rx_mode_t eff_mode;
  assign eff_mode = (mac_rx_end && rx_mode == ts_framer_pkg::RX_FRAME) ?
    ts_framer_pkg::RX_HUNT : rx_mode;

  // Next delineation state and byte hand-off
  ts_framer_pkg::rx_mode_t next_mode;
  logic deliver;
  logic deliver_sof;
  always_comb begin
    next_mode = eff_mode;
    deliver = 1'b0;
    deliver_sof = 1'b0;
    if (!in_frame) begin
      next_mode = ts_framer_pkg::RX_LOST;
    end else if (rx_hdr1 && rx_data[`TS_TEI_BIT]) begin
      next_mode = ts_framer_pkg::RX_LOST;
    end else if (rx_ptr) begin
      if (ptr_bad) begin
        next_mode = ts_framer_pkg::RX_LOST;
      end else if (eff_mode == ts_framer_pkg::RX_LOST) begin
        next_mode = ts_framer_pkg::RX_HUNT;
      end else if (eff_mode == ts_framer_pkg::RX_FRAME
                   && rx_data == 8'h00) begin
        next_mode = ts_framer_pkg::RX_HUNT;
      end
    end else if (rx_pay && rx_skip != 8'h00) begin
      // Tail bytes belong to the frame in progress
      deliver = (eff_mode == ts_framer_pkg::RX_FRAME);
      if (rx_skip == 8'h01 && eff_mode == ts_framer_pkg::RX_FRAME) begin
        next_mode = ts_framer_pkg::RX_HUNT;
      end
    end else if (rx_pay) begin
      case (eff_mode)
        ts_framer_pkg::RX_HUNT: begin
          if (!is_stuff) begin
            deliver = 1'b1;
            deliver_sof = 1'b1;
            next_mode = ts_framer_pkg::RX_FRAME;
          end
        end
        ts_framer_pkg::RX_FRAME: deliver = 1'b1;
        default: deliver = 1'b0;
      endcase
    end
  end

  // Header capture and packet acceptance
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_keep <= 1'b0;
      rx_pusi <= 1'b0;
      rx_pid_hi <= 5'h00;
    end else if (rx_valid && rx_pos == 8'h00) begin
      rx_keep <= (rx_data == `TS_SYNC);
    end else if (rx_hdr1) begin
      rx_pusi <= rx_data[`TS_PUSI_BIT];
      rx_pid_hi <= rx_data[4:0];
      if (rx_data[`TS_TEI_BIT]) begin
        rx_keep <= 1'b0;
      end
    end else if (rx_hdr2) begin
      rx_keep <= rx_keep && pid_match && in_frame;
    end else if (rx_hdr3) begin
      rx_keep <= rx_keep && rx_data[5:4] == `TS_AFC_PAYLOAD;
    end else if (rx_ptr && ptr_bad) begin
      rx_keep <= 1'b0;
    end
  end

  // Pointer skip countdown
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_skip <= 8'h00;
    end else if (rx_valid && rx_pos == 8'h00) begin
      rx_skip <= 8'h00;
    end else if (rx_ptr && !ptr_bad) begin
      rx_skip <= rx_data;
    end else if (rx_pay && rx_skip != 8'h00) begin
      rx_skip <= rx_skip - 8'h01;
    end
  end

  // Delineation state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_mode <= ts_framer_pkg::RX_LOST;
    end else begin
      rx_mode <= next_mode;
    end
  end

  // Registered receive outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_out_data <= 8'h00;
      rx_out_valid <= 1'b0;
      rx_out_sof <= 1'b0;
      rx_ptr_err <= 1'b0;
      rx_in_frame <= 1'b0;
    end else begin
      rx_out_valid <= deliver;
      rx_out_sof <= deliver_sof;
      rx_ptr_err <= rx_ptr && ptr_bad;
      rx_in_frame <= in_frame;
      if (deliver) begin
        rx_out_data <= rx_data;
      end
    end
  end

endmodule

/* File: tb/framer_monitor.sv */
// Port-level assertions for the transport packet framer
module framer_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Transmit side
  input wire logic phy_next,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_sop,
  input wire logic mac_take,
  // Receive side
  input wire logic rx_valid,
  input wire logic rx_cks_ok,
  input wire logic rx_cks_bad,
  input wire logic [7:0] rx_out_data,
  input wire logic rx_out_valid,
  input wire logic rx_out_sof,
  input wire logic rx_in_frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pos;
  logic [3:0] ok_run;
  logic [3:0] bad_run;

  default clocking mon_ck @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Byte index and checksum runs; each checksum kind clears the other
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pos <= 8'h00;
      ok_run <= 4'h0;
      bad_run <= 4'h0;
    end else begin
      if (tx_valid) pos <= (pos == 8'hBB) ? 8'h00 : pos + 8'h01;
      if (rx_cks_ok) ok_run <= ok_run + {3'h0, ok_run != 4'hF};
      if (rx_cks_ok) bad_run <= 4'h0;
      if (rx_cks_bad) bad_run <= bad_run + {3'h0, bad_run != 4'hF};
      if (rx_cks_bad) ok_run <= 4'h0;
    end
  end

  a_next_gives_byte: assert property (phy_next |=> tx_valid)
    else $error("no byte after request");
  a_byte_needs_next: assert property (tx_valid |-> $past(phy_next))
    else $error("byte without request");
  a_sop_at_pos: assert property (tx_valid |-> tx_sop == (pos == 8'h00))
    else $error("packet start off the 188 byte grid");
  a_sync_first: assert property (tx_sop |-> tx_data == 8'h47)
    else $error("bad sync byte");
  a_hdr_flags: assert property (tx_valid && pos == 8'h01 |->
      !tx_data[7] && !tx_data[5])
    else $error("error or priority bit set");
  a_hdr_control: assert property (tx_valid && pos == 8'h03 |->
      tx_data[7:4] == 4'h1)
    else $error("bad scrambling or adaptation field");
  a_take_in_payload: assert property (mac_take |->
      tx_valid && pos > 8'h03)
    else $error("MAC byte taken outside payload");
  a_out_after_in: assert property (rx_out_valid |-> $past(rx_valid))
    else $error("output byte without input byte");
  a_sof_not_filler: assert property (rx_out_sof |->
      rx_out_valid && rx_out_data != 8'hFF)
    else $error("frame start on filler");
  a_acquire_run: assert property ($rose(rx_in_frame) |->
      ok_run >= 4'h5)
    else $error("alignment before five good checksums");
  a_loss_run: assert property ($fell(rx_in_frame) |->
      bad_run >= 4'h9)
    else $error("alignment lost before nine bad checksums");
endmodule

/* File: tb/phy_coder_model.sv */
// Coder stand-in: paces byte requests and loops bytes to the decoder
module phy_coder_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pacing and fault control
  input wire logic [3:0] gap,
  input wire logic bad,
  input wire logic flt,
  // Framer transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_sop,
  output logic phy_next,
  // Framer receive side
  output logic rx_valid,
  output logic rx_sop,
  output logic [7:0] rx_data,
  output logic rx_cks_ok,
  output logic rx_cks_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  logic [7:0] bpos;
  logic pusi_seen;

  // Pointer byte of a start-flagged packet, target of the fault injection
  wire hit_ptr = flt && pusi_seen && bpos == 8'h04;

  // Requests gap cycles apart; idle data inverts so stale bytes never pass
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
      {bpos, pusi_seen} <= '0;
      {phy_next, rx_valid, rx_sop, rx_data, rx_cks_ok, rx_cks_bad} <= '0;
    end else begin
      cnt <= (cnt == 4'h0) ? gap - 4'h1 : cnt - 4'h1;
      phy_next <= (cnt == 4'h0);
      if (tx_valid) bpos <= tx_sop ? 8'h01 : bpos + 8'h01;
      if (tx_valid && bpos == 8'h01) pusi_seen <= tx_data[6];
      rx_valid <= tx_valid;
      rx_sop <= tx_sop;
      rx_data <= tx_valid ? (hit_ptr ? 8'hF0 : tx_data) : ~rx_data;
      rx_cks_ok <= tx_sop & ~bad;
      rx_cks_bad <= tx_sop & bad;
    end
  end
endmodule

/* File: tb/downstream_ts_mac_framer_tb.sv */
// Self-checking bench for the transport packet framer
module downstream_ts_mac_framer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, resetn, tx_enable, mac_valid, mac_sof, mac_stamp, mac_take;
  logic other_req, other_take, phy_next, tx_valid, tx_sop, rx_valid, rx_sop;
  logic rx_cks_ok, rx_cks_bad, mac_rx_end, rx_out_valid, rx_out_sof;
  logic rx_in_frame, rx_ptr_err, bad, pu, flt;
  logic [31:0] tstamp, hd;
  logic [15:0] mac_len;
  logic [7:0] mac_data, other_data, tx_data, rx_data, rx_out_data;
  logic [12:0] pid;
  logic [3:0] gap;
  logic [3:0] cc = 4'h0;
  logic [9:0] ev;
  logic [31:0] src[$];
  logic [9:0] exp_q[$];
  int tl[$];
  int lens[8] = '{1, 183, 184, 185, 400, 2, 60, 367};
  int error_cnt, n_checks, tp, rem, fb, oi, opend, perr;

  downstream_ts_mac_framer dut_u (
    .ref_clk, .resetn, .tx_enable, .tstamp, .mac_valid, .mac_data, .mac_sof,
    .mac_len, .mac_stamp, .mac_take, .other_req, .other_data, .other_take,
    .phy_next, .tx_data, .tx_valid, .tx_sop, .rx_valid, .rx_sop, .rx_data,
    .rx_cks_ok, .rx_cks_bad, .mac_rx_end, .rx_out_data, .rx_out_valid,
    .rx_out_sof, .rx_in_frame, .rx_ptr_err
  );
  phy_coder_model phy_u (
    .ref_clk, .resetn, .gap, .bad, .flt, .tx_data, .tx_valid, .tx_sop,
    .phy_next, .rx_valid, .rx_sop, .rx_data, .rx_cks_ok, .rx_cks_bad
  );

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  function automatic bit done(input int m);
    case (m)
      0: return rx_in_frame === 1'b1;
      1: return rx_in_frame === 1'b0;
      3: return perr > 0;
      default: return exp_q.size() == 0 && opend == 0;
    endcase
  endfunction

  // Bounded wait; running out ends the run at once
  task automatic wt(input int n, input int m);
    for (int k = 0; k < n && !done(m); k++) @(posedge ref_clk);
    chk(done(m), "wait ran out");
    if (!done(m)) close_out();
  endtask

  // Queue one frame at the source and its expected recovery
  task automatic gen(input int len, input bit st);
    logic [7:0] b;
    logic sp;
    for (int k = 0; k < len; k++) begin
      b = 8'($urandom);
      sp = st && k >= 2 && k < 6;
      if (k == 0 && b == 8'hFF) b = 8'h3C;
      src.push_back({len[15:0], 6'h00, sp, k == 0, b});
      if (sp) b = tstamp[8 * (5 - k) +: 8];
      exp_q.push_back({k == len - 1, k == 0, b});
    end
    tl.push_back(len);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Sources: MAC bytes advance on take, other packet is 47 01 00 10 then index
  always @(posedge ref_clk) begin
    if (mac_take === 1'b1 && src.size() > 0) void'(src.pop_front());
    hd = (src.size() > 0) ? src[0] : 32'h0;
    mac_valid <= src.size() > 0;
    {mac_len, mac_stamp, mac_sof, mac_data} <= {hd[31:16], hd[9:0]};
    if (other_take === 1'b1) oi = (oi == 187) ? 0 : oi + 1;
    if (other_take === 1'b1 && oi == 0) opend--;
    other_req <= opend > 0;
    other_data <= (oi < 4) ? 8'(32'h47010010 >> (8 * (3 - oi))) : oi[7:0];
  end

  // Recovered bytes against the queued frames; end each frame after it
  always @(posedge ref_clk) begin
    mac_rx_end <= 1'b0;
    if (rx_out_valid === 1'b1) begin
      chk(exp_q.size() > 0, "extra byte");
      ev = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h000;
      chk(rx_out_data === ev[7:0] && rx_out_sof === ev[8], "rx");
      if (ev[9]) mac_rx_end <= 1'b1;
    end
    if (rx_ptr_err === 1'b1) begin
      chk(flt === 1'b1, "pointer error");
      perr++;
    end
  end

  // Expected transmit stream rebuilt from headers and frame lengths
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1) begin
      if (tx_sop === 1'b1) tp = 0;
      case (tp)
        0: chk(tx_data === 8'h47, "sync");
        1: {pu, pid[12:8]} = {tx_data[6], tx_data[4:0]};
        2: pid[7:0] = tx_data;
        3: begin
          fb = 0;
          if (pid === 13'h1FFE) begin
            chk(tx_data === {4'h1, cc} && pu === (rem < 184), "hdr");
            cc = cc + 4'h1;
          end else begin
            chk(rem == 0 && (pid !== 13'h1FFF || !pu), "kind");
          end
        end
        default: begin
          if (pid === 13'h1FFE && tp == 4 && pu) begin
            chk(tx_data === rem[7:0], "pointer");
          end else if (pid === 13'h1FFE) begin
            if (rem == 0 && tx_data !== 8'hFF) begin
              chk(tl.size() > 0, "frame start");
              rem = (tl.size() > 0) ? tl.pop_front() : 1;
            end
            if (rem > 0) fb++;
            if (rem > 0) rem--;
            if (tp == 187) chk(fb > 0, "filler only");
          end else begin
            chk(tx_data === ((pid === 13'h1FFF) ? 8'hFF : tp[7:0]), "pl");
          end
        end
      endcase
      tp++;
    end
  end

  // Test sequence
  initial begin
    {resetn, tx_enable, bad, flt} = '0;
    tstamp = '0;
    gap = 4'h3;
    void'($urandom(32'hD36C56D0));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    tstamp <= $urandom;
    wt(6000, 0);
    $display("align done");
    tx_enable <= 1'b1;
    foreach (lens[k]) gen(lens[k], k == 4);
    repeat (4) gen(1 + $urandom_range(299), 1'b0);
    wt(40000, 2);
    $display("frames done");
    gap <= 4'h2;
    gen(30, 1'b0);
    opend = 2;
    wt(5000, 2);
    $display("other done");
    flt <= 1'b1;
    gen(30, 1'b0);
    exp_q.delete();
    wt(3000, 3);
    flt <= 1'b0;
    $display("pointer done");
    gap <= 4'h3;
    bad <= 1'b1;
    wt(8000, 1);
    bad <= 1'b0;
    wt(6000, 0);
    gen(90, 1'b0);
    wt(4000, 2);
    gen(40, 1'b1);
    wt(4000, 2);
    $display("loss done");
    chk(tl.size() == 0, "frames left");
    close_out();
  end
endmodule

bind downstream_ts_mac_framer framer_monitor mon_u (
  .ref_clk, .resetn, .phy_next, .tx_data, .tx_valid, .tx_sop, .mac_take,
  .rx_valid, .rx_cks_ok, .rx_cks_bad, .rx_out_data, .rx_out_valid,
  .rx_out_sof, .rx_in_frame
);
